// ==== test/rck_link_model.sv ====
// key switch bank and rf stage stand-in for the transmitter bench
// assumes frames are bracketed by the rf power pin on the bench clock
`timescale 1ns/1ps
`default_nettype none
module rck_link_model (
	// clock
	input  wire logic         aclk,
	// keys held by the bench
	input  wire logic [3:0]   hold,
	// device pins
	input  wire logic         tx_out,
	input  wire logic         rf_stage_power_n,
	output logic [3:0]        button_input_n,
	// last captured frame, newest sample in bit 0
	output int                frame_cnt,
	output int                frame_len,
	output logic [255:0]      frame_smp
);
	int           run_len;
	logic [255:0] run_smp;
	logic         rf_q;
	// switch to ground, an open switch reads high through the pull-up
	assign button_input_n = ~hold;
	initial begin
		frame_cnt = 0;
		frame_len = 0;
		run_len = 0;
		rf_q = 1'b1;
	end
	// the stage only listens while it is powered
	always @(posedge aclk) begin
		rf_q <= rf_stage_power_n;
		if (!rf_stage_power_n) begin
			run_smp <= {run_smp[254:0], tx_out};
			run_len <= run_len + 1;
		end else if (!rf_q) begin
			frame_smp <= run_smp;
			frame_len <= run_len;
			frame_cnt <= frame_cnt + 1;
			run_len <= 0;
		end
	end
endmodule
`default_nettype wire

// ==== test/rck_top_test.sv ====
// self-checking bench for the rolling code transmitter top
// assumes the link model stands in for the keys and the rf stage
`timescale 1ns/1ps
`default_nettype none
`include "rck_consts.svh"
module rck_top_test;
	logic         aclk, aresetn, ce;
	logic [7:0]   s_axi_awaddr, s_axi_araddr;
	logic [31:0]  s_axi_wdata, s_axi_rdata;
	logic [3:0]   s_axi_wstrb, button_input_n, key_pressed, hold;
	logic         s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic         s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic         s_axi_rvalid, s_axi_rready, tx_out, rf_stage_power_n, osc_output_pin;
	logic [1:0]   s_axi_bresp, s_axi_rresp;
	logic [255:0] frame_smp;
	int           frame_cnt, frame_len, error_cnt, checked, l0, l1, l2;

	// short poll and hold counts keep the run brief
	rck_top #(.POLL_CYC(4), .HOLD_CYC(200)) dut (.aclk, .aresetn, .ce,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .button_input_n, .key_pressed, .tx_out,
		.rf_stage_power_n, .osc_output_pin);
	rck_link_model link (.aclk, .hold, .tx_out, .rf_stage_power_n, .button_input_n,
		.frame_cnt, .frame_len, .frame_smp);

	initial begin
		aclk = 1'b0;
		forever #20 aclk = ~aclk;
	end

	task automatic test_done();
		if (error_cnt == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] s);
		checked++;
		if (s !== e) begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", nm, e, s);
		end
	endtask

	task automatic tmo(input int n, input int lim);
		if (n >= lim) begin
			cmp("wait bound", 32'h0, 32'h1);
			test_done();
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int   n;
		logic aw, w;
		n = 0;
		aw = 1'b0;
		w = 1'b0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (n < 60) begin
			@(posedge aclk);
			n++;
			if (!aw && s_axi_awready) begin
				aw = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (!w && s_axi_wready) begin
				w = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
			if (aw && w && s_axi_bvalid)
				break;
		end
		tmo(n, 60);
		s_axi_bready <= 1'b0;
		cmp("bresp", 32'(er), 32'(s_axi_bresp));
		@(posedge aclk);
	endtask

	task automatic rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
		int n;
		n = 0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		while (n < 60) begin
			@(posedge aclk);
			n++;
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid)
				break;
		end
		tmo(n, 60);
		d = s_axi_rdata;
		s_axi_rready <= 1'b0;
		cmp("rresp", 32'(er), 32'(s_axi_rresp));
		@(posedge aclk);
	endtask

	task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		logic [31:0] d;
		rd(a, er, d);
		cmp("rdata", e, d);
	endtask

	task automatic wait_state(input logic [2:0] s);
		logic [31:0] d;
		int          n;
		n = 0;
		d = 32'hffffffff;
		while (d[6:4] !== s && n < 200) begin
			rd(`RCK_OFF_STATUS, `RCK_RESP_OK, d);
			n++;
		end
		tmo(n, 200);
	endtask

	task automatic wait_frame();
		int n, f;
		n = 0;
		f = frame_cnt;
		while (frame_cnt == f && n < 3000) begin
			@(posedge aclk);
			n++;
		end
		tmo(n, 3000);
	endtask

	task automatic do_reset();
		aresetn <= 1'b0;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
	endtask

	task automatic t_regs();
		cmp("pins after reset", 32'h3, {key_pressed, tx_out, rf_stage_power_n, osc_output_pin});
		rc(`RCK_OFF_SEED, {8'h0, `RCK_SEED_RST}, `RCK_RESP_OK);
		rc(`RCK_OFF_KEY_ID, {8'h0, `RCK_KEY_ID_RST}, `RCK_RESP_OK);
		rc(`RCK_OFF_CFG, {19'h0, `RCK_CFG_RST}, `RCK_RESP_OK);
		rc(`RCK_OFF_TIMING, `RCK_TIMING_RST, `RCK_RESP_OK);
		rc(8'h1c, 32'h0, `RCK_RESP_DEC);
		wr(`RCK_OFF_STATUS, 32'h1, `RCK_RESP_SLV);
		wr(`RCK_OFF_SEED, 32'h00123456, `RCK_RESP_OK);
		rc(`RCK_OFF_SEED, 32'h00123456, `RCK_RESP_OK);
		wr(`RCK_OFF_KEY_ID, 32'h00abcdef, `RCK_RESP_OK);
		rc(`RCK_OFF_KEY_ID, 32'h00abcdef, `RCK_RESP_OK);
		wr(`RCK_OFF_TIMING, 32'h00080002, `RCK_RESP_OK);
	endtask

	task automatic t_debounce();
		int n;
		hold <= 4'b0001;
		for (n = 0; n < 20; n++) begin
			@(posedge aclk);
			if (n == 9)
				hold <= 4'b0000;
			cmp("early key", 32'h1, {key_pressed, rf_stage_power_n});
		end
		hold <= 4'b0001;
		n = 0;
		while (key_pressed !== 4'h1 && n < 40) begin
			@(posedge aclk);
			n++;
		end
		tmo(n, 40);
		cmp("debounce time", 32'h1, 32'(n >= 12));
		wait_frame();
		hold <= 4'b0000;
		wait_state(3'h0);
	endtask

	task automatic t_frame(input logic pol, input logic lng, output int len);
		logic [31:0] c1, c2;
		int          n, bl;
		bl = lng ? 36 : 24;
		wr(`RCK_OFF_CFG, {22'h0, pol, lng, 8'ha5}, `RCK_RESP_OK);
		cmp("idle level", 32'(pol), 32'(tx_out));
		hold <= 4'b0101;
		n = 0;
		while (rf_stage_power_n !== 1'b0 && n < 200) begin
			@(posedge aclk);
			n++;
		end
		tmo(n, 200);
		@(posedge aclk);
		cmp("led pin", 32'h0, 32'(osc_output_pin));
		wait_frame();
		rd(`RCK_OFF_CODE, `RCK_RESP_OK, c1);
		wait_frame();
		cmp("pause level", 32'(pol), 32'(tx_out));
		rd(`RCK_OFF_CODE, `RCK_RESP_OK, c2);
		cmp("fresh code", 32'h1, 32'(c1 !== c2));
		cmp("stop bit", 32'(!pol), 32'(frame_smp[0]));
		for (n = 0; n < 4; n++)
			cmp("key nibble", 32'(pol ^ (n % 2 == 0)), 32'(frame_smp[2 * n + 2]));
		for (n = 0; n < 8; n++)
			cmp("sync bit", 32'(pol ^ 8'ha5 >> n & 8'h1), 32'(frame_smp[2 * (bl + 5 + n)]));
		len = frame_len;
		hold <= 4'b0000;
		wait_state(3'h0);
		cmp("rf off when idle", 32'h1, 32'(rf_stage_power_n));
	endtask

	task automatic t_hold();
		int f;
		wr(`RCK_OFF_CFG, 32'h000004a5, `RCK_RESP_OK);
		hold <= 4'b0010;
		wait_state(3'h4);
		f = frame_cnt;
		repeat (300) @(posedge aclk);
		cmp("frames in halt", 32'(f), 32'(frame_cnt));
		cmp("rf in halt", 32'h1, 32'(rf_stage_power_n));
		hold <= 4'b0000;
		wait_state(3'h0);
	endtask

	// crystal mode with the led on the rf pin: rf stays low through the pause
	task automatic t_xtal();
		wr(`RCK_OFF_CFG, 32'h000018a5, `RCK_RESP_OK);
		hold <= 4'b1000;
		wait_state(3'h6);
		cmp("led on rf pin", 32'h0, 32'(rf_stage_power_n));
		cmp("osc pin in xtal", 32'h1, 32'(osc_output_pin));
		hold <= 4'b0000;
		wait_state(3'h0);
	endtask

	// low clock enable must freeze the debounce even with a key held
	task automatic t_freeze();
		ce <= 1'b0;
		hold <= 4'b0001;
		repeat (40) @(posedge aclk);
		cmp("frozen key", 32'h0, 32'(key_pressed));
		ce <= 1'b1;
		hold <= 4'b0000;
		repeat (8) @(posedge aclk);
		cmp("state after freeze", 32'h0, 32'(key_pressed));
	endtask

	task automatic t_lock();
		wr(`RCK_OFF_CTRL, 32'h1, `RCK_RESP_OK);
		wr(`RCK_OFF_CFG, 32'h0, `RCK_RESP_SLV);
		rc(`RCK_OFF_CFG, 32'h000004a5, `RCK_RESP_OK);
		do_reset();
		rc(`RCK_OFF_CFG, {19'h0, `RCK_CFG_RST}, `RCK_RESP_OK);
		wr(`RCK_OFF_CFG, 32'h000000a5, `RCK_RESP_OK);
	endtask

	initial begin
		error_cnt = 0;
		checked = 0;
		hold = 4'h0;
		ce = 1'b1;
		aresetn = 1'b0;
		s_axi_awaddr = 8'h00;
		s_axi_araddr = 8'h00;
		s_axi_wdata = 32'h0;
		s_axi_wstrb = 4'hf;
		s_axi_awvalid = 1'b0;
		s_axi_wvalid = 1'b0;
		s_axi_bready = 1'b0;
		s_axi_arvalid = 1'b0;
		s_axi_rready = 1'b0;
		do_reset();
		t_regs();
		t_debounce();
		t_frame(1'b0, 1'b0, l0);
		t_frame(1'b1, 1'b0, l1);
		t_frame(1'b0, 1'b1, l2);
		cmp("long frame extra", 32'd24, 32'(l2 - l0));
		t_xtal();
		t_freeze();
		t_hold();
		t_lock();
		test_done();
	end
endmodule
`default_nettype wire

// ==== verilog/rck_consts.svh ====
// constants of the rolling code transmitter: offsets, fields, resets, timing
// assumes inclusion by bare name from the design files
`ifndef RCK_CONSTS_SVH
`define RCK_CONSTS_SVH
`define RCK_CLK_HZ        25000000
`define RCK_POLL_MS       10
`define RCK_HOLD_S        80
`define RCK_POLL_SAMPLES  3'h4
`define RCK_OFF_SEED      8'h00
`define RCK_OFF_KEY_ID    8'h04
`define RCK_OFF_CFG       8'h08
`define RCK_OFF_TIMING    8'h0c
`define RCK_OFF_CTRL      8'h10
`define RCK_OFF_STATUS    8'h14
`define RCK_OFF_CODE      8'h18
`define RCK_CFG_LONG      8
`define RCK_CFG_POL       9
`define RCK_CFG_HOLD_EN   10
`define RCK_CFG_XTAL      11
`define RCK_CFG_LED_SEL   12
`define RCK_SEED_RST      24'h000001
`define RCK_KEY_ID_RST    24'h000000
`define RCK_CFG_RST       13'h00a5
`define RCK_TIMING_RST    32'h0fa003e8
`define RCK_NIB_SHORT     4'h9
`define RCK_NIB_LONG      4'hc
`define RCK_RESP_OK       2'h0
`define RCK_RESP_SLV      2'h2
`define RCK_RESP_DEC      2'h3
`endif

// ==== verilog/rck_pkg.sv ====
// types of the rolling code transmitter
// assumes nothing of its surroundings
package rck_pkg;
	typedef enum logic [2:0] {
		ST_IDLE  = 3'h0,
		ST_GEN   = 3'h1,
		ST_SEND  = 3'h3,
		ST_STOP  = 3'h2,
		ST_PAUSE = 3'h6,
		ST_HALT  = 3'h4
	} rck_state_t;
	typedef enum logic [1:0] {
		RK_NONE = 2'h0,
		RK_CFG  = 2'h1,
		RK_CTRL = 2'h2,
		RK_RO   = 2'h3
	} rck_kind_t;
endpackage

// ==== verilog/rck_top.sv ====
// rolling code key transmitter: debounce, code generator, frame fifo, serializer
// assumes one 25 MHz clock, an AXI4-Lite master, and ce high during bus traffic
// How it works
// R1: keys idle high; pressed after four low samples taken 10 ms apart
// R2: a confirmed press raises its indication, wakes the fsm, sends a code
// R3: every frame carries a code from a newly advanced generator, whose 40-bit result never equals the previous one
// R4: configuration lives in writable registers that a lock bit freezes
// R5: user state is a 24-bit seed, 24-bit key identity and 8-bit sync pattern
// R6: 40 generator bits recombine into a 24- or 36-bit code by option
// R7: the sync pattern leads each frame to help the receiver align
// R8: generator mixes its registers non-linearly and feeds output back
// R9: a timer derives bit period and pause from configuration
// R10: rf power pin is low only while a frame is being sent, or with crystal and led select whenever the fsm is busy
// R11: rc clock drives the led on the oscillator pin, crystal with led select on rf pin
// R12: transmit pin carries the serial stream with configurable levels
// R13: reset puts every piece of state except the fifo memory in its initial value
// R14: polarity 0 idles low with ones high; polarity 1 inverts both
// R15: frames repeat for as long as a key stays held
// R16: with hold limit on, holding past 80 s stops frames and halts
// R17: generator is its own module: seed, key id, advance, 40-bit result
`timescale 1ns/1ps
`default_nettype none
`include "rck_consts.svh"

module rck_fifo #(
	parameter int W = 4,
	parameter int D = 16
) (
	// clock
	input  wire logic                 clk,
	input  wire logic                 rst_n,
	input  wire logic                 ce,
	// fill side
	input  wire logic [W-1:0]         in_data,
	input  wire logic                 in_valid,
	output logic                      in_ready,
	// drain side
	output logic [W-1:0]              out_data,
	output logic                      out_valid,
	input  wire logic                 out_ready,
	output logic [$clog2(D):0]        level
);
	localparam int AW = $clog2(D);
	logic [W-1:0] mem [D];
	logic [AW:0]  wr_ptr_reg;
	logic [AW:0]  rd_ptr_reg;
	wire  logic   push = in_valid && in_ready;
	wire  logic   pop  = out_valid && out_ready && ce;

	assign level     = wr_ptr_reg - rd_ptr_reg;
	assign in_ready  = ce && (level != (AW+1)'(D));
	assign out_valid = (level != '0);
	assign out_data  = mem[rd_ptr_reg[AW-1:0]];

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_ptr_reg[AW-1:0]] <= in_data;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
		end else begin
			if (push) begin
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			end
			if (pop) begin
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
			end
		end
	end
endmodule

// replaceable cipher stand-in; the 16-bit counter half guarantees no repeat within 65536 advances
module rck_gen (
	// clock
	input  wire logic        clk,
	input  wire logic        rst_n,
	// seed and identity
	input  wire logic [23:0] seed,
	input  wire logic [23:0] key_id,
	input  wire logic        load,
	// stepping
	input  wire logic        advance,
	output logic [39:0]      result
);
	logic [23:0] mix_reg;
	logic [15:0] cnt_reg;
	wire  logic  fb = mix_reg[23] ^ mix_reg[17] ^ (mix_reg[12] & mix_reg[3])
		^ (mix_reg[20] | mix_reg[7]) ^ result[5];

	assign result = {mix_reg ^ key_id, cnt_reg};

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			mix_reg <= `RCK_SEED_RST;
			cnt_reg <= 16'h0;
		end else if (load) begin
			mix_reg <= seed;
			cnt_reg <= 16'h0;
		end else if (advance) begin
			mix_reg <= {mix_reg[22:0], fb}; // [R8]
			cnt_reg <= cnt_reg + 16'h1; // [R3]
		end
	end
endmodule

module rck_top
	import rck_pkg::*;
#(
	parameter int unsigned POLL_CYC = `RCK_POLL_MS * (`RCK_CLK_HZ / 1000),
	parameter int unsigned HOLD_CYC = `RCK_HOLD_S * `RCK_CLK_HZ
) (
	// clock, reset, freeze
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        ce,
	// axi4-lite write
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// axi4-lite read
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// keys and transmitter pins
	input  wire logic [3:0]  button_input_n,
	output logic [3:0]       key_pressed,
	output logic             tx_out,
	output logic             rf_stage_power_n,
	output logic             osc_output_pin
);
	function automatic rck_kind_t reg_kind(input logic [7:0] a);
		case (a)
			`RCK_OFF_SEED, `RCK_OFF_KEY_ID, `RCK_OFF_CFG, `RCK_OFF_TIMING: reg_kind = RK_CFG;
			`RCK_OFF_CTRL: reg_kind = RK_CTRL;
			`RCK_OFF_STATUS, `RCK_OFF_CODE: reg_kind = RK_RO;
			default: reg_kind = RK_NONE;
		endcase
	endfunction

	function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] d,
		input logic [3:0] s);
		for (int b = 0; b < 4; b++) begin
			old[8*b +: 8] = s[b] ? d[8*b +: 8] : old[8*b +: 8];
		end
		wmerge = old;
	endfunction

	// debounce
	logic [31:0] poll_cnt_reg;
	logic [2:0]  low_cnt_reg [4];
	logic [3:0]  key_pressed_reg;
	wire  logic  poll_tick = (poll_cnt_reg == POLL_CYC - 32'h1);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin // [R13]
			poll_cnt_reg    <= 32'h0;
			key_pressed_reg <= 4'h0;
			for (int k = 0; k < 4; k++) begin
				low_cnt_reg[k] <= 3'h0;
			end
		end else if (ce) begin
			poll_cnt_reg <= poll_tick ? 32'h0 : poll_cnt_reg + 32'h1;
			for (int k = 0; k < 4; k++) begin
				if (poll_tick) begin
					low_cnt_reg[k] <= button_input_n[k] ? 3'h0 :
						(low_cnt_reg[k] == `RCK_POLL_SAMPLES) ? low_cnt_reg[k]
						: low_cnt_reg[k] + 3'h1;
					key_pressed_reg[k] <= !button_input_n[k] &&
						(low_cnt_reg[k] >= `RCK_POLL_SAMPLES - 3'h1); // [R1] [R2]
				end
			end
		end
	end
	assign key_pressed = key_pressed_reg;

	chk_press_after_four: assert property (@(posedge aclk) disable iff (!aresetn) // [R1]
		$rose(key_pressed_reg[0]) |-> $past(poll_tick) && $past(low_cnt_reg[0]) == 3'h3)
		else $error("key indication rose before four low samples");

	// register bus
	logic        aw_full_reg, w_full_reg, bvalid_reg, rvalid_reg, lock_reg;
	logic [7:0]  aw_addr_reg;
	logic [31:0] w_data_reg, rdata_reg, timing_reg;
	logic [3:0]  w_strb_reg;
	logic [1:0]  bresp_reg, rresp_reg;
	logic [23:0] seed_reg, key_id_reg;
	logic [12:0] cfg_reg;
	logic [35:0] code_reg;
	rck_state_t  state_reg, state_next;
	wire  logic [4:0]  fifo_level;
	wire  rck_kind_t   wr_kind  = reg_kind(aw_addr_reg);
	wire  rck_kind_t   rd_kind  = reg_kind(s_axi_araddr);
	wire  logic        do_write = ce && aw_full_reg && w_full_reg && !bvalid_reg;
	wire  logic        wr_cfg   = do_write && wr_kind == RK_CFG && !lock_reg; // [R4]
	wire  logic        wr_seed  = wr_cfg && aw_addr_reg == `RCK_OFF_SEED;
	wire  logic [31:0] wr_val   = wmerge(32'h0, w_data_reg, w_strb_reg);
	wire  logic        rd_take  = s_axi_arvalid && s_axi_arready;
	wire  logic [1:0]  wr_resp  = (wr_kind == RK_NONE) ? `RCK_RESP_DEC :
		(wr_kind == RK_RO || (wr_kind == RK_CFG && lock_reg)) ? `RCK_RESP_SLV : `RCK_RESP_OK;
	wire  logic [31:0] rd_val   =
		(s_axi_araddr == `RCK_OFF_SEED)   ? {8'h0, seed_reg} :
		(s_axi_araddr == `RCK_OFF_KEY_ID) ? {8'h0, key_id_reg} :
		(s_axi_araddr == `RCK_OFF_CFG)    ? {19'h0, cfg_reg} :
		(s_axi_araddr == `RCK_OFF_TIMING) ? timing_reg :
		(s_axi_araddr == `RCK_OFF_CTRL)   ? {31'h0, lock_reg} :
		(s_axi_araddr == `RCK_OFF_STATUS) ? {19'h0, fifo_level, 1'b0, state_reg, key_pressed_reg} :
		(s_axi_araddr == `RCK_OFF_CODE)   ? code_reg[31:0] : 32'h0;

	assign s_axi_awready = ce && !aw_full_reg;
	assign s_axi_wready  = ce && !w_full_reg;
	assign s_axi_arready = ce && !rvalid_reg;
	assign s_axi_bvalid  = bvalid_reg;
	assign s_axi_bresp   = bresp_reg;
	assign s_axi_rvalid  = rvalid_reg;
	assign s_axi_rdata   = rdata_reg;
	assign s_axi_rresp   = rresp_reg;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full_reg <= 1'b0;
			w_full_reg  <= 1'b0;
			bvalid_reg  <= 1'b0;
			rvalid_reg  <= 1'b0;
			aw_addr_reg <= 8'h0;
			w_data_reg  <= 32'h0;
			w_strb_reg  <= 4'h0;
			bresp_reg   <= `RCK_RESP_OK;
			rresp_reg   <= `RCK_RESP_OK;
			rdata_reg   <= 32'h0;
		end else if (ce) begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_full_reg <= 1'b1;
				aw_addr_reg <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_full_reg <= 1'b1;
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
			end
			if (do_write) begin
				aw_full_reg <= 1'b0;
				w_full_reg  <= 1'b0;
				bvalid_reg  <= 1'b1;
				bresp_reg   <= wr_resp;
			end else if (s_axi_bready) begin
				bvalid_reg <= 1'b0;
			end
			if (rd_take) begin
				rvalid_reg <= 1'b1;
				rdata_reg  <= rd_val;
				rresp_reg  <= (rd_kind == RK_NONE) ? `RCK_RESP_DEC : `RCK_RESP_OK;
			end else if (s_axi_rready) begin
				rvalid_reg <= 1'b0;
			end
		end
	end

	// lock is set-only so tampering needs a reset
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			seed_reg   <= `RCK_SEED_RST;
			key_id_reg <= `RCK_KEY_ID_RST;
			cfg_reg    <= `RCK_CFG_RST;
			timing_reg <= `RCK_TIMING_RST;
			lock_reg   <= 1'b0;
		end else if (wr_cfg) begin // [R5]
			case (aw_addr_reg)
				`RCK_OFF_SEED:   seed_reg   <= 24'(wmerge({8'h0, seed_reg}, wr_val, w_strb_reg));
				`RCK_OFF_KEY_ID: key_id_reg <= 24'(wmerge({8'h0, key_id_reg}, wr_val, w_strb_reg));
				`RCK_OFF_CFG:    cfg_reg    <= 13'(wmerge({19'h0, cfg_reg}, wr_val, w_strb_reg));
				default:         timing_reg <= wmerge(timing_reg, wr_val, w_strb_reg);
			endcase
		end else if (do_write && wr_kind == RK_CTRL && w_strb_reg[0] && w_data_reg[0]) begin
			lock_reg <= 1'b1; // [R4]
		end
	end

	chk_lock_freezes: assert property (@(posedge aclk) disable iff (!aresetn) // [R4]
		(lock_reg && do_write) |=> $stable(seed_reg) && $stable(key_id_reg)
			&& $stable(cfg_reg) && $stable(timing_reg))
		else $error("configuration changed while locked");

	// sequencer and timer
	logic [15:0] timer_reg;
	logic [31:0] hold_cnt_reg;
	logic [47:0] frame_reg;
	logic [3:0]  nib_left_reg, sh_reg;
	logic [2:0]  bits_left_reg;
	logic        cur_bit_reg, tx_reg, rf_n_reg, osc_reg;
	wire  logic [39:0] gen_result;
	wire  logic [3:0]  fifo_out;
	wire  logic        fifo_in_ready, fifo_out_valid;
	wire  logic        long_code  = cfg_reg[`RCK_CFG_LONG];
	wire  logic        out_pol    = cfg_reg[`RCK_CFG_POL];
	wire  logic        led_on_rf  = cfg_reg[`RCK_CFG_XTAL] && cfg_reg[`RCK_CFG_LED_SEL];
	wire  logic        any_key    = |key_pressed_reg;
	wire  logic        hold_over  = cfg_reg[`RCK_CFG_HOLD_EN] && hold_cnt_reg > HOLD_CYC; // [R16]
	wire  logic        bit_tick   = (timer_reg == 16'h0);
	wire  logic        tx_phase   = state_reg == ST_SEND || state_reg == ST_STOP;
	wire  logic        busy       = state_reg != ST_IDLE && state_reg != ST_HALT;
	wire  logic        gen_adv    = ce && state_next == ST_GEN && state_reg != ST_GEN;
	wire  logic        fifo_push  = state_reg == ST_SEND && nib_left_reg != 4'h0;
	wire  logic        fifo_take  = ce && state_reg == ST_SEND && bit_tick && bits_left_reg == 3'h0;
	wire  logic        pop        = fifo_take && fifo_out_valid;
	wire  logic        frame_done = fifo_take && !fifo_out_valid && nib_left_reg == 4'h0;
	wire  logic [23:0] code24     = gen_result[39:16] ^ {gen_result[15:0], 8'h00}; // [R6]
	wire  logic [35:0] code36     = {gen_result[39:28] ^ gen_result[11:0], gen_result[27:4]};
	wire  logic [47:0] frame_new  = long_code ? {cfg_reg[7:0], code36, key_pressed_reg} // [R7]
		: {cfg_reg[7:0], code24, key_pressed_reg, 12'h000};
	wire  logic [15:0] timer_load = (state_next == ST_PAUSE && state_reg != ST_PAUSE) ?
		timing_reg[31:16] - 16'h1 : timing_reg[15:0] - 16'h1; // [R9]

	always_comb begin
		state_next = state_reg;
		if (hold_over && state_reg != ST_HALT) begin
			state_next = ST_HALT; // [R16]
		end else begin
			case (state_reg)
				ST_IDLE:  if (any_key) state_next = ST_GEN; // [R2]
				ST_GEN:   state_next = ST_SEND;
				ST_SEND:  if (frame_done) state_next = ST_STOP;
				ST_STOP:  if (bit_tick) state_next = ST_PAUSE;
				ST_PAUSE: if (bit_tick) state_next = any_key ? ST_GEN : ST_IDLE; // [R15]
				ST_HALT:  if (!any_key) state_next = ST_IDLE;
				default:  state_next = ST_IDLE;
			endcase
		end
	end

	rck_gen u_gen ( // [R17]
		.clk     (aclk),
		.rst_n   (aresetn),
		.seed    (seed_reg),
		.key_id  (key_id_reg),
		.load    (ce && wr_seed),
		.advance (gen_adv), // [R3]
		.result  (gen_result)
	);

	// sixteen nibbles hold the longest frame, so the builder never waits on the drain
	rck_fifo #(.W(4), .D(16)) u_fifo (
		.clk       (aclk),
		.rst_n     (aresetn),
		.ce        (ce),
		.in_data   (frame_reg[47:44]),
		.in_valid  (fifo_push),
		.in_ready  (fifo_in_ready),
		.out_data  (fifo_out),
		.out_valid (fifo_out_valid),
		.out_ready (fifo_take),
		.level     (fifo_level)
	);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_reg     <= ST_IDLE;
			timer_reg     <= 16'h0;
			hold_cnt_reg  <= 32'h0;
			frame_reg     <= 48'h0;
			code_reg      <= 36'h0;
			nib_left_reg  <= 4'h0;
			sh_reg        <= 4'h0;
			bits_left_reg <= 3'h0;
			cur_bit_reg   <= 1'b0;
		end else if (ce) begin
			state_reg    <= state_next;
			timer_reg    <= (state_next == ST_GEN) ? 16'h1 : bit_tick ? timer_load
				: timer_reg - 16'h1; // [R9]
			hold_cnt_reg <= !any_key ? 32'h0 : (hold_cnt_reg > HOLD_CYC) ? hold_cnt_reg
				: hold_cnt_reg + 32'h1;
			if (state_reg == ST_GEN) begin
				frame_reg     <= frame_new;
				code_reg      <= long_code ? code36 : {12'h000, code24};
				nib_left_reg  <= long_code ? `RCK_NIB_LONG : `RCK_NIB_SHORT; // [R6]
				bits_left_reg <= 3'h0;
				cur_bit_reg   <= 1'b0;
			end else if (fifo_push && fifo_in_ready) begin
				frame_reg    <= {frame_reg[43:0], 4'h0};
				nib_left_reg <= nib_left_reg - 4'h1;
			end
			if (pop) begin
				cur_bit_reg   <= fifo_out[3];
				sh_reg        <= {fifo_out[2:0], 1'b0};
				bits_left_reg <= 3'h3;
			end else if (state_reg == ST_SEND && bit_tick && bits_left_reg != 3'h0) begin
				cur_bit_reg   <= sh_reg[3];
				sh_reg        <= {sh_reg[2:0], 1'b0};
				bits_left_reg <= bits_left_reg - 3'h1;
			end else if (frame_done) begin
				cur_bit_reg <= 1'b1;
			end
		end
	end

	// pins lag the state by one cycle, all three alike
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tx_reg   <= 1'b0;
			rf_n_reg <= 1'b1;
			osc_reg  <= 1'b1;
		end else if (ce) begin
			tx_reg   <= (tx_phase && cur_bit_reg) ^ out_pol; // [R12] [R14]
			rf_n_reg <= !(led_on_rf ? busy : tx_phase); // [R10] [R11]
			osc_reg  <= cfg_reg[`RCK_CFG_XTAL] || !busy; // [R11]
		end
	end
	assign tx_out           = tx_reg;
	assign rf_stage_power_n = rf_n_reg;
	assign osc_output_pin   = osc_reg;

	chk_press_wakes_fsm: assert property (@(posedge aclk) disable iff (!aresetn) // [R2]
		(ce && state_reg == ST_IDLE && any_key && !hold_over) |=> state_reg == ST_GEN)
		else $error("confirmed press did not start a frame");
	chk_code_rolls: assert property (@(posedge aclk) disable iff (!aresetn) // [R3]
		gen_adv |=> gen_result != $past(gen_result))
		else $error("code repeated after advance");
	chk_code_width: assert property (@(posedge aclk) disable iff (!aresetn) // [R6]
		(ce && state_reg == ST_GEN) |=>
			nib_left_reg == ($past(long_code) ? `RCK_NIB_LONG : `RCK_NIB_SHORT))
		else $error("frame length does not match code option");
	chk_sync_leads: assert property (@(posedge aclk) disable iff (!aresetn) // [R7]
		(ce && state_reg == ST_GEN) |=> frame_reg[47:40] == $past(cfg_reg[7:0]))
		else $error("sync pattern not at frame head");
	chk_rf_only_tx: assert property (@(posedge aclk) disable iff (!aresetn) // [R10]
		(!rf_stage_power_n && !$past(led_on_rf)) |-> $past(tx_phase))
		else $error("rf stage powered outside a frame");
	chk_idle_level: assert property (@(posedge aclk) disable iff (!aresetn) // [R14]
		(ce && state_reg == ST_IDLE) |=> tx_out == $past(out_pol))
		else $error("transmit idle level wrong");
	chk_repeat_held: assert property (@(posedge aclk) disable iff (!aresetn) // [R15]
		(ce && state_reg == ST_PAUSE && bit_tick && any_key
			&& !(cfg_reg[`RCK_CFG_HOLD_EN] && hold_cnt_reg >= HOLD_CYC))
			|=> state_reg == ST_GEN ##1 state_reg == ST_SEND)
		else $error("held key did not repeat the frame");
	chk_hold_halt: assert property (@(posedge aclk) disable iff (!aresetn) // [R16]
		(ce && hold_over && state_reg != ST_HALT) |=> state_reg == ST_HALT)
		else $error("hold limit did not halt");
endmodule
`default_nettype wire
